// ===== tb/rtc_time_control_registers_test.sv
// bench for the clock core: counters, controls, clears and reference
// assumes the host model drives the port; second length cut to 5 ms
`timescale 1ns/1ns
module rtc_time_control_registers_test;
	import rtcr_pkg::*;
	typedef struct {logic [3:0] wa; logic [3:0] wd; int n; logic [3:0] ra; logic [3:0] ex;} rtcr_row_t;
	logic core_clk, arst_n, shiftClk, accessChipSelect_n, supplyGoodSelect, serialIn;
	logic readNotWrite, serialOut, serialOutEn, referencePulseOutput, referencePulseEn;
	int   errTotal, checksDone, n;
	// rows: write address, data, count, then read address and value
	rtcr_row_t rows[9] = '{'{ADR_SEC_U, 4'h0, 3, ADR_SEC_U, 4'h3},
		'{ADR_MIN_U, 4'h0, 12, ADR_MIN_T, 4'h1}, '{ADR_WDAY, 4'h0, 7, ADR_WDAY, 4'h0},
		'{ADR_HOUR_U, 4'h0, 13, ADR_HOUR_T, 4'h8}, '{ADR_CTRL1, 4'h1, 1, ADR_HOUR_T, 4'h9},
		'{ADR_CTRL2, 4'he, 1, ADR_CTRL2, 4'h4}, '{ADR_MON_U, 4'h0, 1, ADR_MON_U, 4'h2},
		'{ADR_DAY_U, 4'h0, 28, ADR_DAY_T, 4'h2}, '{ADR_DAY_U, 4'h0, 1, ADR_MON_U, 4'h3}};
	rtcr_core #(.SEC_CYC(50000), .BUSY_CYC(2000), .REF_HALF(10)) dut (.core_clk, .arst_n,
		.shiftClk, .accessChipSelect_n, .supplyGoodSelect, .serialIn, .readNotWrite,
		.serialOut, .serialOutEn, .referencePulseOutput, .referencePulseEn);
	rtcr_host host (.core_clk, .shiftClk, .accessChipSelect_n, .serialIn, .readNotWrite,
		.serialOut);
	initial
	begin
		core_clk = 1'b0;
		forever #50 core_clk = ~core_clk;
	end
	////////////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [7:0] g, input logic [7:0] e);
		checksDone++;
		if (g !== e)
		begin
			$display("CHECK FAILED at %0t: got %h expected %h", $time, g, e);
			errTotal++;
		end
	endtask : chk
	task automatic wr(input logic [3:0] a, input logic [3:0] d, input int k);
		logic [7:0] g;
		for (int i = 0; i < k; i++)
			host.frame(a, d, 1'b0, g);
		host.idle();
	endtask : wr
	// read word comes back on the following cycle as address then data
	task automatic rd(input logic [3:0] a, input logic [3:0] e);
		logic [7:0] g;
		host.frame(a, 4'h0, 1'b1, g);
		host.frame(a, 4'h0, 1'b1, g);
		host.idle();
		chk(g, {e, a});
	endtask : rd
	task automatic stop_test();
		$display("checks %0d, mismatches %0d", checksDone, errTotal);
		if (errTotal == 0 && checksDone > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : stop_test
	// watchdog: whole run needs about 52500 cycles, most of it waiting for a tick
	initial
	begin
		repeat (70000) @(posedge core_clk);
		errTotal++;
		stop_test();
	end
	initial
	begin
		arst_n = 1'b0;
		supplyGoodSelect = 1'b1;
		errTotal = 0;
		checksDone = 0;
		repeat (10) @(posedge core_clk);
		arst_n <= 1'b1;
		repeat (5) @(posedge core_clk);
		rd(ADR_MON_U, 4'h1);
		rd(ADR_CTRL2, 4'h4);
		foreach (rows[i])
		begin
			wr(rows[i].wa, rows[i].wd, rows[i].n);
			rd(rows[i].ra, rows[i].ex);
		end
		wr(ADR_SEC_T, 4'h0, 3);
		wr(ADR_CTRL1, 4'h5, 1);
		rd(ADR_CTRL1, 4'h1);
		rd(ADR_MIN_U, 4'h3);
		rd(ADR_SEC_T, 4'h0);
		wr(ADR_CTRL1, 4'h5, 1);
		rd(ADR_MIN_U, 4'h3);
		wr(ADR_CTRL1, 4'h3, 1);
		wr(ADR_SEC_U, 4'h0, 1);
		rd(ADR_SEC_U, 4'h0);
		rd(ADR_HOUR_T, 4'h0);
		wr(ADR_CTRL1, 4'h1, 1);
		wr(ADR_CTRL3, 4'h4, 1);
		rd(ADR_CTRL2, 4'h0);
		rd(ADR_MIN_U, 4'h0);
		// user ram bank: the top word shares the address of control two
		wr(ADR_CTRL3, 4'h2, 1);
		wr(4'he, 4'ha, 1);
		rd(4'he, 4'ha);
		wr(ADR_CTRL3, 4'h0, 1);
		supplyGoodSelect <= 1'b0;
		repeat (10) @(posedge core_clk);
		supplyGoodSelect <= 1'b1;
		repeat (5) @(posedge core_clk);
		rd(ADR_CTRL2, 4'h4);
		// fast reference: high phase lasts the half period
		@(posedge referencePulseOutput);
		n = 0;
		while (referencePulseOutput === 1'b1 && n < 100)
		begin
			@(posedge core_clk);
			#1;
			n++;
		end
		chk(n[7:0], 8'h0a);
		chk({7'h0, referencePulseEn}, 8'h01);
		// first tick after the system clear sets busy and counts a second
		repeat (50000) @(posedge core_clk);
		rd(ADR_CTRL2, 4'hc);
		rd(ADR_SEC_U, 4'h1);
		// slow reference stays off inside the holdoff
		wr(ADR_CTRL1, 4'h8, 1);
		chk({7'h0, referencePulseEn}, 8'h00);
		chk({7'h0, serialOutEn}, 8'h00);
		stop_test();
	end
endmodule : rtc_time_control_registers_test

// ===== tb/rtcr_host.sv
// host model: drives the 3-wire serial port of the clock core
// assumes core_clk paces the cycles; the shift clock runs at 15 ns inside a cycle
// and is parked high between cycles, with a pause the core needs for the command
`timescale 1ns/1ns
module rtcr_host
(
	input  wire logic core_clk,
	output logic      shiftClk,
	output logic      accessChipSelect_n,
	output logic      serialIn,
	output logic      readNotWrite,
	input  wire logic serialOut
);
	// idle: shift clock parked high, port deselected
	initial
	begin
		shiftClk = 1'b1;
		accessChipSelect_n = 1'b1;
		serialIn = 1'b0;
		readNotWrite = 1'b1;
	end
	////////////////////////////////////////////////////////////////////////////////
	// one 8-clock cycle, lsb first; got holds serialOut seen at each rise
	task automatic frame(input logic [3:0] adr, input logic [3:0] dat, input logic rd,
		output logic [7:0] got);
		logic [7:0] word;
		word = {dat, adr};
		@(posedge core_clk);
		accessChipSelect_n <= 1'b0;
		readNotWrite <= rd;
		#3;  // shift clock phase unrelated to core_clk
		for (int i = 0; i < 8; i++)
		begin
			shiftClk <= 1'b0;
			serialIn <= word[i];
			#8;
			got[i] = serialOut;
			shiftClk <= 1'b1;
			#7;
		end
		// clock parked high while the core takes the command and the read word
		repeat (10) @(posedge core_clk);
	endtask : frame
	// deselect; the data line no longer shows the last bit
	task automatic idle();
		@(posedge core_clk);
		accessChipSelect_n <= 1'b1;
		serialIn <= ~serialIn;
		repeat (20) @(posedge core_clk);
	endtask : idle
endmodule : rtcr_host

// ===== verilog/rtcr_core.sv
// real-time clock core: bcd time and calendar counters written by increment,
// three control registers, user ram and the reference pulse, behind a 3-wire port.
// assumes shiftClk comes from the host and stops between frames; core_clk is free.
//
// How it works
// [R1] every digit register reads as bcd
// [R2] a counter write increments, carrying, not loads
// [R3] weekday runs 0..6, separate from the date
// [R4] hour format bit selects 12 or 24 presentation
// [R5] afternoon flag set 12:00..23:59, both formats
// [R6] years divisible by four give February 29
// [R7] fixed-zero bits always read zero
// [R8] reference is 1024 hz square or 1/10 hz
// [R9] no slow reference for ten seconds after reset
// [R10] round forces 00 seconds, carries from 30
// [R11] round bit self-clears within 76.3 us
// [R12] host waits or polls round bit before access
// [R13] counter clear holds counters, year excepted
// [R14] host writes counter clear back to zero
// [R15] busy flag shows seconds carry in progress
// [R16] busy lasts 4.9 ms, hazard 0.5 us
// [R17] counter writes in carry hazard window are discarded
// [R18] access completes on eighth shift clock rise
// [R19] power-loss flag set at power-up and failure
// [R20] power-on clear loads fixed calendar and controls
// [R21] host keeps factory test bit at zero
// [R22] control two bit0 write zero, bit1 undefined
// [R23] system clear acts as power-on clear, stays set
// [R24] system clear released on first falling shift clock
// [R25] bank bits select counters or one ram region
`timescale 1ns/1ns
module rtcr_core
#(
	parameter int unsigned SEC_CYC  = rtcr_pkg::SEC_CYC,      // cycles per second
	parameter int unsigned BUSY_CYC = rtcr_pkg::BUSY_CYC,     // busy flag length
	parameter int unsigned REF_HALF = rtcr_pkg::REF_HALF_CYC  // fast reference half period
)
(
	input  wire logic core_clk,            // 10 mhz core clock
	input  wire logic arst_n,              // asynchronous reset, active low
	input  wire logic shiftClk,            // host shift clock, link domain
	input  wire logic accessChipSelect_n,  // port select, active low
	input  wire logic supplyGoodSelect,    // high while system supply is good
	input  wire logic serialIn,            // address then data, lsb first
	input  wire logic readNotWrite,        // high read, low write
	output logic      serialOut,           // echoed address then read data
	output logic      serialOutEn,         // drive enable of serialOut
	output logic      referencePulseOutput,// reference waveform
	output logic      referencePulseEn     // drive enable of the reference
);
	import rtcr_pkg::*;

	localparam int unsigned HAZ_LIM = BUSY_CYC - HAZARD_CYC;  // busy count bound of hazard

	////////////////////////////////////////////////////////////////////////////////
	// link domain
	logic       linkRst_n;      // frame reset: deselect clears the bit counters
	logic [2:0] riseCnt_r;      // rising edges within the 8-bit cycle
	logic [7:0] shift_r;        // incoming bits, lsb first
	logic [7:0] frame;          // shift contents including the current bit
	logic [3:0] cmdAddr_r;      // captured address
	logic [3:0] cmdData_r;      // captured write data
	logic       cmdRead_r;      // captured direction
	logic       reqTgl_r;       // flips once per completed command
	logic [2:0] fallCnt_r;      // falling edges within the cycle
	logic [7:0] outShift_r;     // word being sent
	logic       firstFall_r;    // first fall of this selection seen
	logic       relTgl_r;       // flips on each first fall
	logic [7:0] readWord_r;     // core: {data, address} for the next cycle

	assign linkRst_n = arst_n & ~accessChipSelect_n;
	assign frame     = {serialIn, shift_r[7:1]};

	// bit counter and shifter, cleared whenever the port is deselected
	always_ff @(posedge shiftClk or negedge linkRst_n)
	begin
		if (!linkRst_n)
		begin
			riseCnt_r <= 3'h0;
			shift_r   <= 8'h00;
		end
		else
		begin
			riseCnt_r <= riseCnt_r + 3'h1;
			shift_r   <= frame;
		end
	end

	// command capture on the eighth rise; fields stay stable until the next one
	always_ff @(posedge shiftClk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			cmdAddr_r <= 4'h0;
			cmdData_r <= 4'h0;
			cmdRead_r <= 1'b1;
			reqTgl_r  <= 1'b0;
		end
		else if (linkRst_n && riseCnt_r == 3'h7)
		begin
			cmdAddr_r <= frame[3:0];    // R18
			cmdData_r <= frame[7:4];
			cmdRead_r <= readNotWrite;
			reqTgl_r  <= ~reqTgl_r;     // R18
		end
	end

	// output shifter: bits of the previous word leave on each fall
	always_ff @(negedge shiftClk or negedge linkRst_n)
	begin
		if (!linkRst_n)
		begin
			fallCnt_r <= 3'h0;
			serialOut <= 1'b0;
		end
		else
		begin
			fallCnt_r <= fallCnt_r + 3'h1;
			// first fall of a cycle sends bit 0 of the core word directly
			serialOut <= (fallCnt_r == 3'h0) ? readWord_r[0] : outShift_r[fallCnt_r];
		end
	end

	// the word is taken on the first fall of the next cycle, a clock pause after
	// the request toggled, so the core copy has settled; a host that skips the
	// pause gets the older word.
	always_ff @(negedge shiftClk or negedge arst_n)
	begin
		if (!arst_n)
			outShift_r <= 8'h00;
		else if (linkRst_n && fallCnt_r == 3'h0)
			outShift_r <= readWord_r;
	end

	// first falling edge after selection releases system clear
	always_ff @(negedge shiftClk or negedge linkRst_n)
	begin
		if (!linkRst_n)
			firstFall_r <= 1'b0;
		else
			firstFall_r <= 1'b1;
	end

	always_ff @(negedge shiftClk or negedge arst_n)
	begin
		if (!arst_n)
			relTgl_r <= 1'b0;
		else if (linkRst_n && !firstFall_r)
			relTgl_r <= ~relTgl_r;      // R24
	end

	////////////////////////////////////////////////////////////////////////////////
	// crossings into the core domain
	logic [2:0] reqS_r, relS_r;       // [0] meta, [1] sync, [2] last
	logic [1:0] csS_r, goodS_r;       // [0] meta, [1] sync
	logic       reqEdge, relEdge;

	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			reqS_r  <= 3'h0;
			relS_r  <= 3'h0;
			csS_r   <= 2'h0;
			goodS_r <= 2'h0;
		end
		else
		begin
			reqS_r  <= {reqS_r[1:0], reqTgl_r};
			relS_r  <= {relS_r[1:0], relTgl_r};
			csS_r   <= {csS_r[0], ~accessChipSelect_n};
			goodS_r <= {goodS_r[0], supplyGoodSelect};
		end
	end
	assign reqEdge = reqS_r[2] ^ reqS_r[1];
	assign relEdge = relS_r[2] ^ relS_r[1];

	// port drives only while selected and the supply is good
	assign serialOutEn = csS_r[1] & goodS_r[1];

	////////////////////////////////////////////////////////////////////////////////
	// bcd helpers
	function automatic logic [6:0] bcd2bin(input logic [7:0] v);
		return 7'(v[7:4]) * 7'd10 + 7'(v[3:0]);
	endfunction : bcd2bin

	function automatic logic [7:0] bin2bcd(input logic [6:0] b);
		return {4'(b / 7'd10), 4'(b % 7'd10)};
	endfunction : bin2bcd

	// add in binary, wrap into lo..hi, report the carry out
	function automatic logic [8:0] stepBcd(input logic [7:0] v, input logic [6:0] add,
		input logic [6:0] lo, input logic [6:0] hi);
		logic [7:0] n;
		logic       c;
		n = {1'b0, bcd2bin(v)} + {1'b0, add};
		c = 1'b0;
		if (n > {1'b0, hi})
		begin
			n = n - ({1'b0, hi} - {1'b0, lo} + 8'd1);
			c = 1'b1;
		end
		return {c, bin2bcd(n[6:0])};   // R1
	endfunction : stepBcd

	// month length, leap every fourth year
	function automatic logic [6:0] dayMax(input logic [7:0] mon, input logic [7:0] yr);
		logic [6:0] m;
		logic [6:0] y;
		m = bcd2bin(mon);
		y = bcd2bin(yr);
		if (m == 7'd2)
			return (y[1:0] == 2'b00) ? 7'd29 : 7'd28;   // R6
		else if (m == 7'd4 || m == 7'd6 || m == 7'd9 || m == 7'd11)
			return 7'd30;
		else
			return 7'd31;
	endfunction : dayMax

	////////////////////////////////////////////////////////////////////////////////
	// registers
	logic [7:0] sec_r, min_r, hour_r, day_r, mon_r, year_r;  // bcd counters
	logic [3:0] wday_r;                                      // weekday code
	logic [3:0] ctrl1_r;          // pulse, round, clear, 24h
	logic       ploss_r;          // power_loss_flag
	logic [3:0] ctrl3_r;          // test, system clear, bank bits
	logic [3:0] ram_r [0:2*RAM_WORDS-1];
	logic [23:0] subCnt_r;        // sub-second prescaler
	logic [15:0] busyCnt_r;       // busy countdown
	logic        busyFlag, hazard, tick, counterBank, cmdWrite;
	logic        incGo, adjGo, clearing;

	assign busyFlag    = busyCnt_r != 16'h0;                      // R15
	assign hazard      = busyCnt_r > 16'(HAZ_LIM);                // R16
	assign tick        = subCnt_r == 24'(SEC_CYC - 1);
	assign counterBank = !ctrl3_r[C3_BANKH];                      // R25
	assign cmdWrite    = reqEdge && !cmdRead_r;
	assign clearing    = ctrl1_r[C1_CLEAR] || ctrl3_r[C3_SYS];
	// counter writes: not in clear, not in the carry hazard, not on a tick
	assign incGo = cmdWrite && counterBank && cmdAddr_r <= ADR_YEAR_T
		&& !clearing && !hazard && !tick;                         // R2 R17
	assign adjGo = ctrl1_r[C1_ROUND] && !incGo && !tick && !clearing;

	////////////////////////////////////////////////////////////////////////////////
	// carry chain
	logic [7:0] secN, minN, hourN, dayN, monN, yTmpLow;
	logic [8:0] yTmp;
	logic [3:0] wdayN;
	logic       cS, cM, cH, cD, cMo, tensSel;
	logic [6:0] incAmt;

	always_comb
	begin
		tensSel = cmdAddr_r == ADR_SEC_T || cmdAddr_r == ADR_MIN_T || cmdAddr_r == ADR_HOUR_T
			|| cmdAddr_r == ADR_DAY_T || cmdAddr_r == ADR_MON_T || cmdAddr_r == ADR_YEAR_T;
		incAmt = tensSel ? 7'd10 : 7'd1;
		{cS, secN} = stepBcd(sec_r, tick ? 7'd1
			: (incGo && cmdAddr_r <= ADR_SEC_T) ? incAmt : 7'd0, 7'd0, 7'd59);
		if (adjGo)
		begin
			secN = RST_SEC;                  // R10
			cS   = sec_r >= 8'h30;           // R10
		end
		{cM, minN} = stepBcd(min_r, cS ? 7'd1 : (incGo && (cmdAddr_r == ADR_MIN_U
			|| cmdAddr_r == ADR_MIN_T)) ? incAmt : 7'd0, 7'd0, 7'd59);
		{cH, hourN} = stepBcd(hour_r, cM ? 7'd1 : (incGo && (cmdAddr_r == ADR_HOUR_U
			|| cmdAddr_r == ADR_HOUR_T)) ? incAmt : 7'd0, 7'd0, 7'd23);
		// weekday steps on midnight or its own write, never from the date
		wdayN = wday_r;
		if (cH || (incGo && cmdAddr_r == ADR_WDAY))
			wdayN = (wday_r >= 4'h6) ? 4'h0 : wday_r + 4'h1;   // R3
		{cD, dayN} = stepBcd(day_r, cH ? 7'd1 : (incGo && (cmdAddr_r == ADR_DAY_U
			|| cmdAddr_r == ADR_DAY_T)) ? incAmt : 7'd0, 7'd1, dayMax(mon_r, year_r));
		{cMo, monN} = stepBcd(mon_r, cD ? 7'd1 : (incGo && (cmdAddr_r == ADR_MON_U
			|| cmdAddr_r == ADR_MON_T)) ? incAmt : 7'd0, 7'd1, 7'd12);
		yTmp = stepBcd(year_r, cMo ? 7'd1 : (incGo && (cmdAddr_r == ADR_YEAR_U
			|| cmdAddr_r == ADR_YEAR_T)) ? incAmt : 7'd0, 7'd0, 7'd99);
		yTmpLow = yTmp[7:0];   // year carry past 99 is dropped
	end

	// time and calendar counters
	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			sec_r <= RST_SEC; min_r <= RST_MIN; hour_r <= RST_HOUR;   // R20
			wday_r <= RST_WDAY; day_r <= RST_DAY; mon_r <= RST_MON;
			year_r <= RST_YEAR;
		end
		else if (clearing)
		begin
			// counter clear spares the year; system clear does not   R13 R23
			sec_r <= RST_SEC; min_r <= RST_MIN; hour_r <= RST_HOUR;
			wday_r <= RST_WDAY; day_r <= RST_DAY; mon_r <= RST_MON;
			if (ctrl3_r[C3_SYS])
				year_r <= RST_YEAR;
		end
		else
		begin
			sec_r <= secN; min_r <= minN; hour_r <= hourN;   // R2
			wday_r <= wdayN; day_r <= dayN; mon_r <= monN;
			year_r <= yTmpLow;
		end
	end

	// prescaler and busy window; clearing the seconds clears the prescaler
	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			subCnt_r  <= 24'h0;
			busyCnt_r <= 16'h0;
		end
		else
		begin
			subCnt_r <= (clearing || tick) ? 24'h0 : subCnt_r + 24'h1;   // R13
			if (tick && !clearing)
				busyCnt_r <= 16'(BUSY_CYC);   // R16
			else if (busyFlag)
				busyCnt_r <= busyCnt_r - 16'h1;
		end
	end

	// control registers; round bit drops the cycle after it acts
	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			ctrl1_r <= RST_CTRL;   // R20
			ctrl3_r <= RST_CTRL;
			ploss_r <= 1'b1;       // R19
		end
		else
		begin
			if (ctrl3_r[C3_SYS])
			begin
				ctrl1_r <= RST_CTRL;      // R23
				ctrl3_r <= {1'b0, !relEdge, 2'b00};   // R24
				ploss_r <= 1'b0;
			end
			else if (cmdWrite && cmdAddr_r == ADR_CTRL3)
				ctrl3_r <= cmdData_r;     // R25
			else if (cmdWrite && counterBank && cmdAddr_r == ADR_CTRL1)
				ctrl1_r <= cmdData_r;
			else if (adjGo)
				ctrl1_r[C1_ROUND] <= 1'b0;   // R11
			// a supply failure wins over a concurrent clear
			if (!goodS_r[1])
				ploss_r <= 1'b1;          // R19
		end
	end

	// user ram, banks of fifteen words
	always_ff @(posedge core_clk)
	begin
		if (cmdWrite && !counterBank && cmdAddr_r != ADR_CTRL3)
			ram_r[ctrl3_r[C3_BANKL] ? 5'(cmdAddr_r) + 5'(RAM_WORDS) : 5'(cmdAddr_r)]
				<= cmdData_r;
	end

	////////////////////////////////////////////////////////////////////////////////
	// read path
	logic [6:0] hourBin, hourShown;
	logic [7:0] hourBcd;
	logic       pmFlag;
	logic [3:0] readNib;

	always_comb
	begin
		hourBin   = bcd2bin(hour_r);
		pmFlag    = hourBin >= 7'd12;                                    // R5
		hourShown = hourBin;
		if (!ctrl1_r[C1_H24])
			hourShown = (hourBin % 7'd12 == 7'd0) ? 7'd12 : hourBin % 7'd12;   // R4
		hourBcd = bin2bcd(hourShown);
		readNib = 4'h0;
		if (!counterBank && cmdAddr_r != ADR_CTRL3)
			readNib = ram_r[ctrl3_r[C3_BANKL] ? 5'(cmdAddr_r) + 5'(RAM_WORDS)
				: 5'(cmdAddr_r)];
		else
		begin
			unique case (cmdAddr_r)
				ADR_SEC_U:  readNib = sec_r[3:0];
				ADR_SEC_T:  readNib = {1'b0, sec_r[6:4]};          // R7
				ADR_MIN_U:  readNib = min_r[3:0];
				ADR_MIN_T:  readNib = {1'b0, min_r[6:4]};
				ADR_HOUR_U: readNib = hourBcd[3:0];
				ADR_HOUR_T: readNib = {pmFlag, 1'b0, hourBcd[5:4]};  // R5 R7
				ADR_WDAY:   readNib = {1'b0, wday_r[2:0]};
				ADR_DAY_U:  readNib = day_r[3:0];
				ADR_DAY_T:  readNib = {2'b00, day_r[5:4]};
				ADR_MON_U:  readNib = mon_r[3:0];
				ADR_MON_T:  readNib = {3'b000, mon_r[4]};
				ADR_YEAR_U: readNib = year_r[3:0];
				ADR_YEAR_T: readNib = year_r[7:4];
				ADR_CTRL1:  readNib = ctrl1_r;
				ADR_CTRL2:  readNib = {busyFlag, ploss_r, 2'b00};   // R15 R22
				ADR_CTRL3:  readNib = ctrl3_r;
			endcase
		end
	end

	// read word held until the next read completes
	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
			readWord_r <= 8'h00;
		else if (reqEdge && cmdRead_r)
			readWord_r <= {readNib, cmdAddr_r};
	end

	////////////////////////////////////////////////////////////////////////////////
	// reference pulse
	logic [12:0] refCnt_r;    // fast half-period counter
	logic        fastRef_r;   // 1024 hz square wave
	logic [3:0]  slowCnt_r;   // seconds within the 10 s period
	logic [3:0]  holdCnt_r;   // seconds since reset or system clear

	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			refCnt_r  <= 13'h0;
			fastRef_r <= 1'b0;
			slowCnt_r <= 4'h0;
			holdCnt_r <= 4'h0;
		end
		else
		begin
			if (clearing || refCnt_r == 13'(REF_HALF - 1))
				refCnt_r <= 13'h0;
			else
				refCnt_r <= refCnt_r + 13'h1;
			if (clearing)
				fastRef_r <= 1'b0;
			else if (refCnt_r == 13'(REF_HALF - 1))
				fastRef_r <= ~fastRef_r;   // R8
			if (clearing || (tick && slowCnt_r == 4'(SLOW_PERIOD - 1)))
				slowCnt_r <= 4'h0;
			else if (tick)
				slowCnt_r <= slowCnt_r + 4'h1;
			if (ctrl3_r[C3_SYS])
				holdCnt_r <= 4'h0;         // R9
			else if (tick && holdCnt_r < 4'(HOLDOFF_SEC))
				holdCnt_r <= holdCnt_r + 4'h1;
		end
	end

	// slow wave low for the first six seconds, silent during holdoff
	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			referencePulseOutput <= 1'b0;
			referencePulseEn     <= 1'b0;
		end
		else
		begin
			referencePulseOutput <= ctrl1_r[C1_PULSE]
				? slowCnt_r >= 4'(SLOW_LOW) : fastRef_r;   // R8
			referencePulseEn <= goodS_r[1]
				&& (!ctrl1_r[C1_PULSE] || holdCnt_r >= 4'(HOLDOFF_SEC));   // R9
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// checks
	sequence roundReq;
		adjGo && sec_r >= 8'h30;
	endsequence

	busy_rise_a: assert property (@(posedge core_clk) disable iff (!arst_n)   // R15
		(tick && !clearing) |=> busyFlag && hazard)
		else $error("busy flag did not rise on the seconds carry");
	hazard_drop_a: assert property (@(posedge core_clk) disable iff (!arst_n)   // R17
		(reqEdge && !cmdRead_r && hazard && !clearing) |=> $stable(hour_r))
		else $error("counter changed by a write in the carry window");
	round_carry_a: assert property (@(posedge core_clk) disable iff (!arst_n)   // R10
		roundReq |=> sec_r == 8'h00 && min_r != $past(min_r))
		else $error("round did not carry into the minutes");
	round_clear_a: assert property (@(posedge core_clk) disable iff (!arst_n)   // R11
		$rose(ctrl1_r[C1_ROUND]) && !clearing |-> ##[1:8] !ctrl1_r[C1_ROUND])
		else $error("round bit did not clear in time");
	clear_hold_a: assert property (@(posedge core_clk) disable iff (!arst_n)   // R13
		ctrl1_r[C1_CLEAR] |=> sec_r == RST_SEC && day_r == RST_DAY && subCnt_r == 24'h0)
		else $error("counter clear did not hold the counters");
	weekday_range_a: assert property (@(posedge core_clk) disable iff (!arst_n)   // R3
		wday_r <= 4'h6)
		else $error("weekday code out of range");
	sys_clear_a: assert property (@(posedge core_clk) disable iff (!arst_n)   // R23
		(ctrl3_r[C3_SYS] && goodS_r[1]) |=> year_r == RST_YEAR && mon_r == RST_MON && !ploss_r)
		else $error("system clear did not load the cleared state");
	loss_flag_a: assert property (@(posedge core_clk) disable iff (!arst_n)   // R19
		!goodS_r[1] |=> ploss_r)
		else $error("power-loss flag not set on supply failure");
	fast_ref_a: assert property (@(posedge core_clk) disable iff (!arst_n)   // R8
		(refCnt_r == 13'(REF_HALF - 1) && !clearing) |=> fastRef_r != $past(fastRef_r))
		else $error("fast reference did not toggle at the half period");
	slow_hold_a: assert property (@(posedge core_clk) disable iff (!arst_n)   // R9
		(holdCnt_r < 4'(HOLDOFF_SEC) && ctrl1_r[C1_PULSE]) |=> !referencePulseEn)
		else $error("slow reference driven during holdoff");

endmodule : rtcr_core

// ===== verilog/rtcr_pkg.sv
// constants shared by the real-time clock core: register offsets, control bit
// positions, power-on clear values and timing counts.
// assumes a 10 MHz core clock; long counts are overridable at the core's top.
package rtcr_pkg;

	// core clock rate and derived cycle counts
	localparam int unsigned CORE_HZ      = 10_000_000;     // core_clk rate in hertz
	localparam int unsigned SEC_CYC      = CORE_HZ;        // core cycles per second
	localparam int unsigned BUSY_NS      = 4_900_000;      // carry flag duration, ns
	localparam int unsigned BUSY_CYC     = BUSY_NS / (1_000_000_000 / CORE_HZ);
	localparam int unsigned HAZARD_NS    = 500;            // real access hazard, ns
	localparam int unsigned HAZARD_CYC   = (HAZARD_NS + (1_000_000_000 / CORE_HZ) - 1)
		/ (1_000_000_000 / CORE_HZ);
	localparam int unsigned ROUND_NS     = 76_300;         // longest round-bit life, ns
	localparam int unsigned ROUND_CYC    = ROUND_NS / (1_000_000_000 / CORE_HZ);
	localparam int unsigned REF_HZ       = 1024;           // fast reference rate
	localparam int unsigned REF_HALF_CYC = CORE_HZ / (2 * REF_HZ);
	localparam int unsigned SLOW_PERIOD  = 10;             // slow reference period, s
	localparam int unsigned SLOW_LOW     = 6;              // low part of that period, s
	localparam int unsigned HOLDOFF_SEC  = 10;             // slow reference holdoff, s

	// register offsets inside the counter bank
	localparam logic [3:0] ADR_SEC_U  = 4'h0;
	localparam logic [3:0] ADR_SEC_T  = 4'h1;
	localparam logic [3:0] ADR_MIN_U  = 4'h2;
	localparam logic [3:0] ADR_MIN_T  = 4'h3;
	localparam logic [3:0] ADR_HOUR_U = 4'h4;
	localparam logic [3:0] ADR_HOUR_T = 4'h5;
	localparam logic [3:0] ADR_WDAY   = 4'h6;
	localparam logic [3:0] ADR_DAY_U  = 4'h7;
	localparam logic [3:0] ADR_DAY_T  = 4'h8;
	localparam logic [3:0] ADR_MON_U  = 4'h9;
	localparam logic [3:0] ADR_MON_T  = 4'ha;
	localparam logic [3:0] ADR_YEAR_U = 4'hb;
	localparam logic [3:0] ADR_YEAR_T = 4'hc;
	localparam logic [3:0] ADR_CTRL1  = 4'hd;
	localparam logic [3:0] ADR_CTRL2  = 4'he;
	localparam logic [3:0] ADR_CTRL3  = 4'hf;

	// control bit positions
	localparam int C1_PULSE = 3;   // pulse_rate_select
	localparam int C1_ROUND = 2;   // half_minute_round
	localparam int C1_CLEAR = 1;   // counter_clear
	localparam int C1_H24   = 0;   // 24-hour format
	localparam int C2_BUSY  = 3;   // carry busy flag
	localparam int C2_PLOSS = 2;   // power_loss_flag
	localparam int C3_TEST  = 3;   // factory test bit
	localparam int C3_SYS   = 2;   // system_clear
	localparam int C3_BANKH = 1;   // bank_select_high
	localparam int C3_BANKL = 0;   // bank_select_low

	// power-on clear values, bcd; hour kept internally as 24-hour 00 = 12 am
	localparam logic [7:0] RST_SEC  = 8'h00;
	localparam logic [7:0] RST_MIN  = 8'h00;
	localparam logic [7:0] RST_HOUR = 8'h00;
	localparam logic [3:0] RST_WDAY = 4'h0;
	localparam logic [7:0] RST_DAY  = 8'h01;
	localparam logic [7:0] RST_MON  = 8'h01;
	localparam logic [7:0] RST_YEAR = 8'h00;
	localparam logic [3:0] RST_CTRL = 4'h0;

	// user ram words per bank
	localparam int RAM_WORDS = 15;

endpackage : rtcr_pkg
